// ===== core/fan_zone_gpio_regs.v
`timescale 1ns/1ps
`include "fan_gpio_defines.vh"

module fan_zone_gpio_regs #(
  parameter TEMP_W = 8,
  parameter CHANNELS = 10,
  parameter PINS = 4
) (
  input wire sys_clk_i,
  input wire rstn_i,
  // register port
  input wire wr_en_i,
  input wire rd_en_i,
  input wire [7:0] addr_i,
  input wire [7:0] wr_data_i,
  output reg [7:0] rd_data_o,
  output reg rd_valid_o,
  // temperature sources
  input wire [TEMP_W-1:0] temp_max_i,
  input wire [TEMP_W*CHANNELS-1:0] temp_ch_i,
  output wire [TEMP_W-1:0] fan3_temp_o,
  output wire [TEMP_W-1:0] fan4_temp_o,
  // fan drive pins, index 0 is pin 1
  input wire [PINS-1:0] fan_pwm_i,
  input wire [PINS-1:0] min_duty_lsb_i,
  input wire [PINS-1:0] pin_in_i,
  output reg [PINS-1:0] pin_out_o,
  output reg [PINS-1:0] pin_oe_o,
  // decoded settings for other blocks
  output wire [3:0] fan3_source_code_o,
  output wire [3:0] fan4_source_code_o,
  output wire [PINS-1:0] pin_io_mode_o
);

  reg [7:0] src_select_q;
  reg [7:0] io_mode_en_q;
  reg [7:0] io_dir_pol_q;
  reg [PINS-1:0] io_status_q;
  reg [PINS-1:0] io_status_d;
  reg [7:0] rd_data_d;
  reg [PINS-1:0] mode_q;

  wire [PINS-1:0] pin_io_mode;
  wire [PINS-1:0] pin_direction;
  wire [PINS-1:0] pin_polarity;
  wire [PINS-1:0] status_wr_data;
  wire [PINS-1:0] pin_asserted_in;
  wire [3:0] fan3_source_code;
  wire [3:0] fan4_source_code;

  function hit;
    input [7:0] a;
    input [7:0] target;
    begin
      hit = (a == target);
    end
  endfunction

  // source select fields
  assign fan3_source_code = src_select_q[`FAN3_SRC_MSB:`FAN3_SRC_LSB];
  assign fan4_source_code = src_select_q[`FAN4_SRC_MSB:`FAN4_SRC_LSB];

  // per pin field mapping
  genvar i;
  generate
    for (i = 0; i < PINS; i = i + 1) begin : g_map
      assign pin_io_mode[i] = io_mode_en_q[`IO_MODE_PIN1_BIT - i];
      assign pin_direction[i] = io_dir_pol_q[`DIR_PIN1_BIT - 2*i];
      assign pin_polarity[i] = io_dir_pol_q[`POL_PIN1_BIT - 2*i];
      assign status_wr_data[i] = wr_data_i[`STATUS_PIN1_BIT + i];
      // asserted when the input level equals the polarity
      assign pin_asserted_in[i] = (pin_in_i[i] == pin_polarity[i]);
    end
  endgenerate

  // configuration registers
  always @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      src_select_q <= `RST_SRC_SELECT;
      io_mode_en_q <= `RST_IO_MODE_EN;
      io_dir_pol_q <= `RST_IO_DIR_POL;
    end else if (wr_en_i) begin
      if (hit(addr_i, `ADDR_SRC_SELECT)) begin
        src_select_q <= wr_data_i;
      end
      // reserved upper bits stored as written; software keeps them zero
      if (hit(addr_i, `ADDR_IO_MODE_EN)) begin
        io_mode_en_q <= wr_data_i;
      end
      if (hit(addr_i, `ADDR_IO_DIR_POL)) begin
        io_dir_pol_q <= wr_data_i;
      end
    end
  end

  // status bits: inputs track the pin, outputs take software writes
  // a bit set while the pin was an input stays set when it turns output,
  // so the pin asserts at once; software rewrites status after a direction change
  integer n;
  always @* begin
    io_status_d = io_status_q;
    for (n = 0; n < PINS; n = n + 1) begin
      if (!pin_direction[n]) begin
        io_status_d[n] = pin_asserted_in[n];
      end else if (wr_en_i && hit(addr_i, `ADDR_IO_STATUS)) begin
        io_status_d[n] = status_wr_data[n];
      end
    end
  end

  always @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      io_status_q <= `RST_IO_STATUS;
    end else begin
      io_status_q <= io_status_d;
    end
  end

  // pin drive, registered
  reg [PINS-1:0] pin_out_d;
  reg [PINS-1:0] pin_oe_d;
  reg asserted;
  integer m;
  always @* begin
    pin_out_d = {PINS{1'b0}};
    pin_oe_d = {PINS{1'b0}};
    asserted = 1'b0;
    for (m = 0; m < PINS; m = m + 1) begin
      asserted = io_status_q[m] | min_duty_lsb_i[m];
      if (!pin_io_mode[m]) begin
        pin_out_d[m] = fan_pwm_i[m];
        pin_oe_d[m] = 1'b1;
      end else if (pin_direction[m]) begin
        // active high drives the asserted state high, active low drives it low
        pin_out_d[m] = asserted ~^ pin_polarity[m];
        pin_oe_d[m] = 1'b1;
      end else begin
        pin_out_d[m] = 1'b0;
        pin_oe_d[m] = 1'b0;
      end
    end
  end

  always @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      pin_out_o <= {PINS{1'b0}};
      pin_oe_o <= {PINS{1'b0}};
    end else begin
      pin_out_o <= pin_out_d;
      pin_oe_o <= pin_oe_d;
    end
  end

  // read path
  // status test bits 3:0 are not stored and read as zero
  always @* begin
    rd_data_d = 8'h00;
    if (hit(addr_i, `ADDR_SRC_SELECT)) begin
      rd_data_d = src_select_q;
    end else if (hit(addr_i, `ADDR_IO_MODE_EN)) begin
      rd_data_d = io_mode_en_q;
    end else if (hit(addr_i, `ADDR_IO_DIR_POL)) begin
      rd_data_d = io_dir_pol_q;
    end else if (hit(addr_i, `ADDR_IO_STATUS)) begin
      rd_data_d = {io_status_q, 4'h0};
    end
  end

  always @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rd_data_o <= 8'h00;
      rd_valid_o <= 1'b0;
    end else begin
      rd_valid_o <= rd_en_i;
      if (rd_en_i) begin
        rd_data_o <= rd_data_d;
      end
    end
  end

  // settings handed on, registered copies
  reg [7:0] src_copy_q;
  always @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      src_copy_q <= `RST_SRC_SELECT;
      mode_q <= {PINS{1'b0}};
    end else begin
      src_copy_q <= {fan3_source_code, fan4_source_code};
      mode_q <= pin_io_mode;
    end
  end

  assign fan3_source_code_o = src_copy_q[`FAN3_SRC_MSB:`FAN3_SRC_LSB];
  assign fan4_source_code_o = src_copy_q[`FAN4_SRC_MSB:`FAN4_SRC_LSB];
  assign pin_io_mode_o = mode_q;

  // temperature source per fan
  temp_source_mux #(
    .TEMP_W(TEMP_W),
    .CHANNELS(CHANNELS)
  ) u_fan3_mux (
    .sys_clk_i(sys_clk_i),
    .rstn_i(rstn_i),
    .source_code_i(fan3_source_code),
    .temp_max_i(temp_max_i),
    .temp_ch_i(temp_ch_i),
    .temp_sel_o(fan3_temp_o)
  );

  temp_source_mux #(
    .TEMP_W(TEMP_W),
    .CHANNELS(CHANNELS)
  ) u_fan4_mux (
    .sys_clk_i(sys_clk_i),
    .rstn_i(rstn_i),
    .source_code_i(fan4_source_code),
    .temp_max_i(temp_max_i),
    .temp_ch_i(temp_ch_i),
    .temp_sel_o(fan4_temp_o)
  );

endmodule // fan_zone_gpio_regs

// ===== core/temp_source_mux.v
`timescale 1ns/1ps
`include "fan_gpio_defines.vh"

module temp_source_mux #(
  parameter TEMP_W = 8,
  parameter CHANNELS = 10
) (
  input wire sys_clk_i,
  input wire rstn_i,
  input wire [3:0] source_code_i,
  input wire [TEMP_W-1:0] temp_max_i,
  input wire [TEMP_W*CHANNELS-1:0] temp_ch_i,
  output reg [TEMP_W-1:0] temp_sel_o
);

  // code 0 and codes above the last channel fall back to the maximum
  function [TEMP_W-1:0] pick;
    input [3:0] code;
    input [TEMP_W-1:0] tmax;
    input [TEMP_W*CHANNELS-1:0] tch;
    integer k;
    begin
      pick = tmax;
      for (k = 0; k < CHANNELS; k = k + 1) begin
        if (code == k[3:0] + 4'h1) begin
          pick = tch[k*TEMP_W +: TEMP_W];
        end
      end
    end
  endfunction

  always @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      temp_sel_o <= {TEMP_W{1'b0}};
    end else begin
      temp_sel_o <= pick(source_code_i, temp_max_i, temp_ch_i);
    end
  end

endmodule // temp_source_mux

// ===== include/fan_gpio_defines.vh
`ifndef FAN_GPIO_DEFINES_VH
`define FAN_GPIO_DEFINES_VH

`define ADDR_SRC_SELECT 8'h7D
`define ADDR_IO_MODE_EN 8'h7F
`define ADDR_IO_DIR_POL 8'h80
`define ADDR_IO_STATUS 8'h81

`define RST_SRC_SELECT 8'h00
`define RST_IO_MODE_EN 8'h00
`define RST_IO_DIR_POL 8'h00
`define RST_IO_STATUS 4'h0

`define FAN3_SRC_MSB 7
`define FAN3_SRC_LSB 4
`define FAN4_SRC_MSB 3
`define FAN4_SRC_LSB 0

`define SRC_CODE_MAX 4'h0
`define SRC_CODE_LAST_CH 4'hA

`define IO_MODE_PIN1_BIT 3
`define DIR_PIN1_BIT 7
`define POL_PIN1_BIT 6
`define STATUS_PIN1_BIT 4

`endif

// ===== testbench/fan_zone_gpio_regs_chk.sv
`timescale 1ns/1ps
module fan_zone_gpio_regs_chk (
  input wire sys_clk_i,
  input wire rstn_i,
  input wire wr_en_i,
  input wire [7:0] addr_i,
  input wire [7:0] wr_data_i,
  input wire rd_valid_o,
  input wire [7:0] temp_max_i,
  input wire [79:0] temp_ch_i,
  input wire [7:0] fan3_temp_o,
  input wire [7:0] fan4_temp_o,
  input wire [3:0] fan_pwm_i,
  input wire [3:0] pin_out_o,
  input wire [3:0] pin_oe_o,
  input wire [3:0] fan3_source_code_o,
  input wire [3:0] fan4_source_code_o,
  input wire [3:0] pin_io_mode_o
);
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!rstn_i);
  function automatic [7:0] sel(input [3:0] c, input [7:0] m, input [79:0] t);
    sel = (c == 4'h0 || c > 4'hA) ? m : t[c*8-8 +: 8];
  endfunction
  property p_f3c;
    wr_en_i && addr_i == 8'h7D |=> ##1 fan3_source_code_o == $past(wr_data_i[7:4], 2);
  endproperty
  a_f3c: assert property (p_f3c) else $error("fan3 code");
  property p_f4c;
    wr_en_i && addr_i == 8'h7D |=> ##1 fan4_source_code_o == $past(wr_data_i[3:0], 2);
  endproperty
  a_f4c: assert property (p_f4c) else $error("fan4 code");
  property p_f3t;
    $past(rstn_i) && $stable(fan3_source_code_o)
      |-> fan3_temp_o == $past(sel(fan3_source_code_o, temp_max_i, temp_ch_i));
  endproperty
  a_f3t: assert property (p_f3t) else $error("fan3 temp");
  property p_f4t;
    $past(rstn_i) && $stable(fan4_source_code_o)
      |-> fan4_temp_o == $past(sel(fan4_source_code_o, temp_max_i, temp_ch_i));
  endproperty
  a_f4t: assert property (p_f4t) else $error("fan4 temp");
  property p_mode;
    wr_en_i && addr_i == 8'h7F |=> ##1
      pin_io_mode_o == {$past(wr_data_i[0], 2), $past(wr_data_i[1], 2),
                        $past(wr_data_i[2], 2), $past(wr_data_i[3], 2)};
  endproperty
  a_mode: assert property (p_mode) else $error("io mode");
  property p_fan;
    $past(rstn_i) |-> (pin_oe_o | pin_io_mode_o) == 4'hF
      && ((pin_out_o ^ $past(fan_pwm_i)) & ~pin_io_mode_o) == 4'h0;
  endproperty
  a_fan: assert property (p_fan) else $error("fan pin");
  property p_rsrc;
    $rose(rstn_i) |-> {fan3_source_code_o, fan4_source_code_o} == 8'h00 ##1
      {fan3_source_code_o, fan4_source_code_o} == 8'h00;
  endproperty
  a_rsrc: assert property (p_rsrc) else $error("src reset");
  property p_rmod;
    $rose(rstn_i) |-> pin_io_mode_o == 4'h0 ##1 pin_io_mode_o == 4'h0;
  endproperty
  a_rmod: assert property (p_rmod) else $error("mode reset");
  c_wsrc: cover property (wr_en_i && addr_i == 8'h7D);
  c_io: cover property (pin_io_mode_o == 4'hF);
  c_rd: cover property (rd_valid_o);
endmodule // fan_zone_gpio_regs_chk
bind fan_zone_gpio_regs fan_zone_gpio_regs_chk u_chk (
  .sys_clk_i(sys_clk_i),
  .rstn_i(rstn_i),
  .wr_en_i(wr_en_i),
  .addr_i(addr_i),
  .wr_data_i(wr_data_i),
  .rd_valid_o(rd_valid_o),
  .temp_max_i(temp_max_i),
  .temp_ch_i(temp_ch_i),
  .fan3_temp_o(fan3_temp_o),
  .fan4_temp_o(fan4_temp_o),
  .fan_pwm_i(fan_pwm_i),
  .pin_out_o(pin_out_o),
  .pin_oe_o(pin_oe_o),
  .fan3_source_code_o(fan3_source_code_o),
  .fan4_source_code_o(fan4_source_code_o),
  .pin_io_mode_o(pin_io_mode_o)
);

// ===== testbench/fan_zone_gpio_regs_tb.sv
`timescale 1ns/1ps
module fan_zone_gpio_regs_tb;
  reg sys_clk_i = 0, rstn_i = 0, wr_en_i = 0, rd_en_i = 0;
  reg [7:0] addr_i = 8'h00, wr_data_i = 8'h00, temp_max_i = 8'hF0;
  reg [79:0] temp_ch_i = 80'h0;
  reg [3:0] fan_pwm_i = 4'hA, min_duty_lsb_i = 4'h1, pin_in_i = 4'h0;
  wire [7:0] rd_data_o, fan3_temp_o, fan4_temp_o;
  wire rd_valid_o;
  wire [3:0] pin_out_o, pin_oe_o, fan3_source_code_o, fan4_source_code_o, pin_io_mode_o;
  integer err_count = 0, n_tests = 0, i, c;
  fan_zone_gpio_regs dut (
    .sys_clk_i(sys_clk_i),
    .rstn_i(rstn_i),
    .wr_en_i(wr_en_i),
    .rd_en_i(rd_en_i),
    .addr_i(addr_i),
    .wr_data_i(wr_data_i),
    .rd_data_o(rd_data_o),
    .rd_valid_o(rd_valid_o),
    .temp_max_i(temp_max_i),
    .temp_ch_i(temp_ch_i),
    .fan3_temp_o(fan3_temp_o),
    .fan4_temp_o(fan4_temp_o),
    .fan_pwm_i(fan_pwm_i),
    .min_duty_lsb_i(min_duty_lsb_i),
    .pin_in_i(pin_in_i),
    .pin_out_o(pin_out_o),
    .pin_oe_o(pin_oe_o),
    .fan3_source_code_o(fan3_source_code_o),
    .fan4_source_code_o(fan4_source_code_o),
    .pin_io_mode_o(pin_io_mode_o)
  );
  initial begin
    forever #25 sys_clk_i = ~sys_clk_i;
  end
  function [7:0] te(input [3:0] s);
    te = (s == 4'h0 || s > 4'hA) ? 8'hF0 : 8'h10 + {4'h0, s};
  endfunction
  task end_sim;
    begin
      $display("checks %0d mismatches %0d", n_tests, err_count);
      if (err_count == 0 && n_tests > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
    end
  endtask
  task chk(input [7:0] got, input [7:0] exp);
    begin
      n_tests = n_tests + 1;
      if (got !== exp) begin
        err_count = err_count + 1;
        $display("BAD %0t got %h exp %h", $time, got, exp);
      end
    end
  endtask
  task wr(input [7:0] a, input [7:0] d);
    begin
      wr_en_i = 1;
      addr_i = a;
      wr_data_i = d;
      @(posedge sys_clk_i) #1;
      wr_en_i = 0;
      repeat (3) @(posedge sys_clk_i) #1;
    end
  endtask
  task rd(input [7:0] a, input [7:0] e);
    begin
      rd_en_i = 1;
      addr_i = a;
      @(posedge sys_clk_i) #1;
      rd_en_i = 0;
      for (i = 0; i < 4 && rd_valid_o !== 1'b1; i = i + 1) @(posedge sys_clk_i) #1;
      if (i == 4) begin
        err_count = err_count + 1;
        end_sim;
      end
      else chk(rd_data_o, e);
      @(posedge sys_clk_i) #1;
    end
  endtask
  initial begin
    for (c = 1; c <= 10; c = c + 1) temp_ch_i[8*c-8 +: 8] = c[7:0] + 8'h10;
    repeat (5) @(posedge sys_clk_i) #1;
    rstn_i = 1;
    rd(8'h7D, 8'h00);
    rd(8'h7F, 8'h00);
    rd(8'h55, 8'h00);
    chk({4'h0, pin_oe_o}, 8'h0F);
    chk({4'h0, pin_out_o}, 8'h0A);
    $display("reset test done");
    for (c = 0; c < 12; c = c + 1) begin
      wr(8'h7D, {c[3:0], 4'hB - c[3:0]});
      chk(fan3_temp_o, te(c[3:0]));
      chk(fan4_temp_o, te(4'hB - c[3:0]));
    end
    rd(8'h7D, 8'hB0);
    $display("source test done");
    wr(8'h7F, 8'h08);
    chk({4'h0, pin_io_mode_o}, 8'h01);
    chk({4'h0, pin_oe_o}, 8'h0E);
    wr(8'h7F, 8'h0F);
    wr(8'h80, 8'hE4);
    wr(8'h81, 8'h00);
    chk({4'h0, pin_oe_o}, 8'h03);
    chk({4'h0, pin_out_o}, 8'h03);
    min_duty_lsb_i = 4'h2;
    repeat (2) @(posedge sys_clk_i) #1;
    chk({4'h0, pin_out_o}, 8'h00);
    $display("pin test done");
    pin_in_i = 4'h4;
    repeat (2) @(posedge sys_clk_i) #1;
    rd(8'h81, 8'hC0);
    pin_in_i = 4'h8;
    repeat (2) @(posedge sys_clk_i) #1;
    rd(8'h81, 8'h00);
    min_duty_lsb_i = 4'h0;
    wr(8'h81, 8'hF0);
    rd(8'h81, 8'h30);
    chk({4'h0, pin_out_o}, 8'h01);
    $display("status test done");
    end_sim;
  end
endmodule // fan_zone_gpio_regs_tb
